// ==== include/lsr_pkg.sv ====
// constants for the level, setpoint and digital i/o router
package lsr_pkg;
	localparam int N_CH     = 4;
	localparam int WEIGHT_W = 32;
	localparam int SRC_W    = 3;
	localparam int DIN_W    = 3;
	localparam int DOUT_W   = 4;

	// supervised signal selection, shared by level and setpoint channels
	localparam logic [SRC_W-1:0] SRC_UNUSED    = 3'h0;
	localparam logic [SRC_W-1:0] SRC_NET       = 3'h1;
	localparam logic [SRC_W-1:0] SRC_GROSS     = 3'h2;
	localparam logic [SRC_W-1:0] SRC_DISP      = 3'h3;
	localparam logic [SRC_W-1:0] SRC_ABS_NET   = 3'h4;
	localparam logic [SRC_W-1:0] SRC_ABS_GROSS = 3'h5;
	localparam logic [SRC_W-1:0] SRC_ABS_DISP  = 3'h6;

	// digital input use
	localparam logic [DIN_W-1:0] DIN_UNUSED  = 3'h0;
	localparam logic [DIN_W-1:0] DIN_TARE    = 3'h1;
	localparam logic [DIN_W-1:0] DIN_TOGGLE  = 3'h2;
	localparam logic [DIN_W-1:0] DIN_GROSS   = 3'h3;
	localparam logic [DIN_W-1:0] DIN_NET     = 3'h4;
	localparam logic [DIN_W-1:0] DIN_ZERO    = 3'h5;
	localparam logic [DIN_W-1:0] DIN_WEIGHT  = 3'h6;
	localparam logic [DIN_W-1:0] DIN_PRINT   = 3'h7;

	// digital output source
	localparam logic [DOUT_W-1:0] DOUT_UNUSED  = 4'h0;
	localparam logic [DOUT_W-1:0] DOUT_REMOTE  = 4'h1;
	localparam logic [DOUT_W-1:0] DOUT_PROCESS = 4'h2;
	localparam logic [DOUT_W-1:0] DOUT_LEVEL1  = 4'h3;
	localparam logic [DOUT_W-1:0] DOUT_SETPT1  = 4'h7;
	localparam logic [DOUT_W-1:0] DOUT_NETMODE = 4'hb;
	localparam logic [DOUT_W-1:0] DOUT_GOODZERO = 4'hc;
	localparam logic [DOUT_W-1:0] DOUT_STABLE  = 4'hd;

	// weights and hysteresis are in hundredths of a measurement unit
	localparam int HYST_SCALE   = 100;
	localparam int HYST_LIMIT   = 999999;
	localparam logic signed [WEIGHT_W-1:0] HYST_MAX     = 32'sh05f5_e09c;
	localparam logic signed [WEIGHT_W-1:0] HYST_DEFAULT = 32'sh0000_0014;
	localparam logic [SRC_W-1:0]  LEVEL_SRC_DEFAULT = 3'h0;
	localparam logic               LEVEL_BELOW_DEFAULT = 1'h0;
	localparam logic [DOUT_W-1:0] DOUT_SRC_DEFAULT  = 4'h1;

	localparam int SYNC_STAGES = 3;
endpackage : lsr_pkg

// ==== design/lsr_din_sync.sv ====
// pin synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ns
module lsr_din_sync
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level_r,
	output logic      rise_r
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level_r <= 1'b0;
			rise_r  <= 1'b0;
		end
		else
		begin
			rise_r <= 1'b0;
			if (s2_r == s3_r)
			begin
				level_r <= s3_r;
				rise_r  <= s3_r & ~level_r; // R19
			end
		end
	end
endmodule : lsr_din_sync

// ==== design/lsr_level_chan.sv ====
// one supervision channel: threshold compare with hysteresis band
`timescale 1ns/1ns
module lsr_level_chan
#(
	parameter int VW = 33
)
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 sample_en,
	input  wire logic                 chan_en,
	input  wire logic                 below,
	input  wire logic signed [VW-1:0] value,
	input  wire logic signed [VW-1:0] level,
	input  wire logic signed [VW-1:0] hyst,
	output logic                      active_r
);
	localparam int TW = VW + 1;

	logic signed [TW-1:0] hi;
	logic signed [TW-1:0] lo;
	logic signed [TW-1:0] val_x;
	logic                 over_r;
	logic                 over_nxt;
	logic                 seen_r;

	// band above the level for positive hysteresis, below it for negative
	always_comb
	begin
		val_x = TW'(value);
		hi    = TW'(level) + ((hyst > 0) ? TW'(hyst) : '0); // R7
		lo    = TW'(level) + ((hyst < 0) ? TW'(hyst) : '0); // R7
		over_nxt = over_r;
		if (val_x > hi)
			over_nxt = 1'b1;
		else if (val_x < lo)
			over_nxt = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			over_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else if (!chan_en)
		begin
			over_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else if (sample_en)
		begin
			over_r <= over_nxt; // R18
			seen_r <= 1'b1;
		end
	end

	// no output before the first sample, so below-polarity does not fire early
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			active_r <= 1'b0;
		else
			active_r <= chan_en & seen_r & (below ? ~over_r : over_r); // R5 R6 R2
	end
endmodule : lsr_level_chan

// ==== design/lsr_router.sv ====
// level supervision, setpoints and digital input/output routing
// Functional notes
// (R1) Four level channels, each with own source, polarity and hysteresis.
// (R2) Unused level source holds every output assigned to it inactive.
// (R3) Level compares net, gross or displayed weight; default source unused.
// (R4) Absolute level source compares the magnitude of the chosen weight.
// (R5) Above polarity, the default: active while signal exceeds switch level.
// (R6) Below polarity: active while signal is lower than switch level.
// (R7) Positive hysteresis puts band above the level, negative below.
// (R8) Hysteresis is signed, magnitude up to 999999 units, default 0.2.
// (R9) Four setpoint channels on net, gross or displayed weight, signed or absolute.
// (R10) Unused setpoint source, the default, holds its outputs inactive.
// (R11) Absolute setpoint source evaluates the magnitude of the chosen weight.
// (R12) Inputs may issue tare, zero or print; unassigned inputs are ignored.
// (R13) Inputs may toggle gross/net, force gross, force net or weight mode.
// (R14) Remote output source, the default, follows the network-written value.
// (R15) Outputs may follow any level channel or any setpoint channel.
// (R16) Outputs may follow in-process, net mode, good zero or stable weight.
// (R17) Output with unused source stays permanently inactive.
// (R18) Comparisons re-evaluate each new sample; state holds inside the band.
// (R19) Command inputs fire once per synchronised rising edge, not while held.
`timescale 1ns/1ns
module lsr_router
#(
	parameter int N  = lsr_pkg::N_CH,
	parameter int W  = lsr_pkg::WEIGHT_W
)
(
	input  wire logic                              clk_sys,
	input  wire logic                              rst_n,
	input  wire logic                              sample_valid,
	input  wire logic signed [W-1:0]               net_weight,
	input  wire logic signed [W-1:0]               gross_weight,
	input  wire logic signed [W-1:0]               disp_weight,
	input  wire logic [N*lsr_pkg::SRC_W-1:0]       level_src,
	input  wire logic [N-1:0]                      level_below,
	input  wire logic [N*W-1:0]                    level_value,
	input  wire logic [N*W-1:0]                    level_hyst,
	input  wire logic [N*lsr_pkg::SRC_W-1:0]       setpt_src,
	input  wire logic [N*W-1:0]                    setpt_value,
	input  wire logic [N*lsr_pkg::DIN_W-1:0]       din_use,
	input  wire logic [N-1:0]                      din_pin,
	input  wire logic [N*lsr_pkg::DOUT_W-1:0]      dout_src,
	input  wire logic [N-1:0]                      remote_out,
	input  wire logic                              stat_in_process,
	input  wire logic                              stat_net_mode,
	input  wire logic                              stat_good_zero,
	input  wire logic                              stat_stable,
	output logic [N-1:0]                           dout_r,
	output logic [N-1:0]                           level_state_r,
	output logic [N-1:0]                           setpt_state_r,
	output logic [N-1:0]                           din_level_r,
	output logic                                   cmd_tare_r,
	output logic                                   cmd_zero_r,
	output logic                                   cmd_print_r,
	output logic                                   cmd_toggle_gn_r,
	output logic                                   cmd_gross_r,
	output logic                                   cmd_net_r,
	output logic                                   cmd_weight_mode_r
);
	localparam int VW = W + 1;

	// signed or magnitude view of one weight, one bit wider so abs never wraps
	function automatic logic signed [VW-1:0] sel_value
	(
		input logic [lsr_pkg::SRC_W-1:0] src,
		input logic signed [W-1:0]       nw,
		input logic signed [W-1:0]       gw,
		input logic signed [W-1:0]       dw
	);
		logic signed [VW-1:0] v;
		v = '0;
		unique case (src)
			lsr_pkg::SRC_NET:       v = VW'(nw);
			lsr_pkg::SRC_GROSS:     v = VW'(gw);
			lsr_pkg::SRC_DISP:      v = VW'(dw);
			lsr_pkg::SRC_ABS_NET:   v = (nw < 0) ? -VW'(nw) : VW'(nw); // R4 R11
			lsr_pkg::SRC_ABS_GROSS: v = (gw < 0) ? -VW'(gw) : VW'(gw); // R4 R11
			lsr_pkg::SRC_ABS_DISP:  v = (dw < 0) ? -VW'(dw) : VW'(dw); // R4 R11
			default:                v = '0;
		endcase
		return v;
	endfunction : sel_value

	// out-of-range settings are clipped rather than wrapped
	function automatic logic signed [W-1:0] clamp_hyst
	(
		input logic signed [W-1:0] h
	);
		logic signed [W-1:0] r;
		r = h;
		if (h > lsr_pkg::HYST_MAX)
			r = lsr_pkg::HYST_MAX;
		else if (h < -lsr_pkg::HYST_MAX)
			r = -lsr_pkg::HYST_MAX;
		return r;
	endfunction : clamp_hyst

	function automatic logic src_used
	(
		input logic [lsr_pkg::SRC_W-1:0] src
	);
		return (src != lsr_pkg::SRC_UNUSED) && (src <= lsr_pkg::SRC_ABS_DISP);
	endfunction : src_used

	logic                 sample_d_r;
	logic signed [W-1:0]  net_r;
	logic signed [W-1:0]  gross_r;
	logic signed [W-1:0]  disp_r;
	logic [N-1:0]         level_act;
	logic [N-1:0]         setpt_act;
	logic [N-1:0]         din_rise;
	logic [N-1:0]         din_lvl;

	// weights captured with the sample so channels see one consistent set
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_d_r <= 1'b0;
			net_r      <= '0;
			gross_r    <= '0;
			disp_r     <= '0;
		end
		else
		begin
			sample_d_r <= sample_valid; // R18
			if (sample_valid)
			begin
				net_r   <= net_weight;
				gross_r <= gross_weight;
				disp_r  <= disp_weight;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_chan
			logic [lsr_pkg::SRC_W-1:0] lsrc;
			logic [lsr_pkg::SRC_W-1:0] ssrc;
			logic signed [VW-1:0]      lval;
			logic signed [VW-1:0]      sval;
			logic signed [VW-1:0]      lthr;
			logic signed [VW-1:0]      sthr;
			logic signed [VW-1:0]      lhys;

			assign lsrc = level_src[g*lsr_pkg::SRC_W +: lsr_pkg::SRC_W];
			assign ssrc = setpt_src[g*lsr_pkg::SRC_W +: lsr_pkg::SRC_W];
			assign lval = sel_value(lsrc, net_r, gross_r, disp_r); // R3
			assign sval = sel_value(ssrc, net_r, gross_r, disp_r); // R9
			assign lthr = VW'($signed(level_value[g*W +: W]));
			assign sthr = VW'($signed(setpt_value[g*W +: W]));
			assign lhys = VW'(clamp_hyst($signed(level_hyst[g*W +: W]))); // R8

			lsr_level_chan #(.VW(VW)) u_level
			(
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.sample_en (sample_d_r),
				.chan_en   (src_used(lsrc)), // R1 R2
				.below     (level_below[g]),
				.value     (lval),
				.level     (lthr),
				.hyst      (lhys),
				.active_r  (level_act[g])
			);

			// setpoint: plain above-threshold compare with no band
			lsr_level_chan #(.VW(VW)) u_setpt
			(
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.sample_en (sample_d_r),
				.chan_en   (src_used(ssrc)), // R10
				.below     (1'b0),
				.value     (sval),
				.level     (sthr),
				.hyst      ('0),
				.active_r  (setpt_act[g])
			);

			lsr_din_sync u_din
			(
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.pin     (din_pin[g]),
				.level_r (din_lvl[g]),
				.rise_r  (din_rise[g])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level_state_r <= '0;
			setpt_state_r <= '0;
			din_level_r   <= '0;
		end
		else
		begin
			level_state_r <= level_act;
			setpt_state_r <= setpt_act;
			din_level_r   <= din_lvl;
		end
	end

	// command decode: a rising edge on any input assigned to a command fires it
	logic [7:0] cmd_hit;

	always_comb
	begin
		cmd_hit = '0;
		for (int i = 0; i < N; i++)
		begin
			if (din_rise[i])
				cmd_hit[din_use[i*lsr_pkg::DIN_W +: lsr_pkg::DIN_W]] = 1'b1; // R12 R13 R19
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_tare_r        <= 1'b0;
			cmd_zero_r        <= 1'b0;
			cmd_print_r       <= 1'b0;
			cmd_toggle_gn_r   <= 1'b0;
			cmd_gross_r       <= 1'b0;
			cmd_net_r         <= 1'b0;
			cmd_weight_mode_r <= 1'b0;
		end
		else
		begin
			// unused inputs land on bit zero, which nothing reads
			cmd_tare_r        <= cmd_hit[lsr_pkg::DIN_TARE];   // R12
			cmd_zero_r        <= cmd_hit[lsr_pkg::DIN_ZERO];   // R12
			cmd_print_r       <= cmd_hit[lsr_pkg::DIN_PRINT];  // R12
			cmd_toggle_gn_r   <= cmd_hit[lsr_pkg::DIN_TOGGLE]; // R13
			cmd_gross_r       <= cmd_hit[lsr_pkg::DIN_GROSS];  // R13
			cmd_net_r         <= cmd_hit[lsr_pkg::DIN_NET];    // R13
			cmd_weight_mode_r <= cmd_hit[lsr_pkg::DIN_WEIGHT]; // R13
		end
	end

	// output routing
	logic [N-1:0] dout_nxt;

	always_comb
	begin
		logic [lsr_pkg::DOUT_W-1:0] s;
		s = '0;
		dout_nxt = '0;
		for (int i = 0; i < N; i++)
		begin
			s = dout_src[i*lsr_pkg::DOUT_W +: lsr_pkg::DOUT_W];
			if (s == lsr_pkg::DOUT_REMOTE)
				dout_nxt[i] = remote_out[i]; // R14
			else if (s == lsr_pkg::DOUT_PROCESS)
				dout_nxt[i] = stat_in_process; // R16
			else if (s >= lsr_pkg::DOUT_LEVEL1 && s < lsr_pkg::DOUT_SETPT1)
				dout_nxt[i] = level_act[2'(s - lsr_pkg::DOUT_LEVEL1)]; // R15 R2
			else if (s >= lsr_pkg::DOUT_SETPT1 && s < lsr_pkg::DOUT_NETMODE)
				dout_nxt[i] = setpt_act[2'(s - lsr_pkg::DOUT_SETPT1)]; // R15 R10
			else if (s == lsr_pkg::DOUT_NETMODE)
				dout_nxt[i] = stat_net_mode; // R16
			else if (s == lsr_pkg::DOUT_GOODZERO)
				dout_nxt[i] = stat_good_zero; // R16
			else if (s == lsr_pkg::DOUT_STABLE)
				dout_nxt[i] = stat_stable; // R16
			else
				dout_nxt[i] = 1'b0; // R17
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			dout_r <= '0;
		else
			dout_r <= dout_nxt;
	end
endmodule : lsr_router

// ==== sim/lsr_io_model.sv ====
// switch contacts on the digital inputs
`timescale 1ns/1ns
module lsr_io_model
#(
	parameter int N = 4
)
(
	input  wire logic         clk_sys,
	input  wire logic [N-1:0] sw_cmd,
	output logic      [N-1:0] din_pin
);
	// contacts move on the rising edge, away from the bench's falling-edge drive
	always @(posedge clk_sys)
		din_pin <= sw_cmd;
endmodule : lsr_io_model

// ==== sim/lsr_router_chk.sv ====
// port-level assertions for the router
`timescale 1ns/1ns
module lsr_router_chk
#(
	parameter int N = 4
)
(
	input wire logic           clk_sys,
	input wire logic           rst_n,
	input wire logic           sample_valid,
	input wire logic [N*3-1:0] level_src,
	input wire logic [N-1:0]   level_below,
	input wire logic [N*3-1:0] setpt_src,
	input wire logic [N*3-1:0] din_use,
	input wire logic [N*4-1:0] dout_src,
	input wire logic [N-1:0]   remote_out,
	input wire logic           stat_in_process,
	input wire logic [N-1:0]   dout_r,
	input wire logic [N-1:0]   level_state_r,
	input wire logic [N-1:0]   setpt_state_r,
	input wire logic           cmd_tare_r,
	input wire logic           cmd_zero_r,
	input wire logic           cmd_print_r,
	input wire logic           cmd_toggle_gn_r,
	input wire logic           cmd_gross_r,
	input wire logic           cmd_net_r,
	input wire logic           cmd_weight_mode_r
);
	logic [6:0] cmd_all;
	assign cmd_all = {cmd_tare_r, cmd_zero_r, cmd_print_r, cmd_toggle_gn_r, cmd_gross_r, cmd_net_r, cmd_weight_mode_r};
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	unused_dout_a: assert property (dout_src[3:0] == 4'h0 |=> !dout_r[0])
		else $error("output with no source went active");
	remote_follow_a: assert property (dout_src[3:0] == 4'h1 |=> dout_r[0] == $past(remote_out[0]))
		else $error("remote output did not follow");
	status_follow_a: assert property (dout_src[7:4] == 4'h2 |=> dout_r[1] == $past(stat_in_process))
		else $error("status output did not follow");
	tare_pulse_a: assert property (cmd_tare_r |=> !cmd_tare_r)
		else $error("command pulse longer than one cycle");
	unused_din_a: assert property ((din_use == '0) [*8] |-> cmd_all == 7'h0)
		else $error("command from unassigned inputs");
	level_unused_a: assert property ((level_src[2:0] == 3'h0) [*5] |-> !level_state_r[0])
		else $error("unused level channel active");
	setpt_unused_a: assert property ((setpt_src[2:0] == 3'h0) [*5] |-> !setpt_state_r[0])
		else $error("unused setpoint active");
	state_hold_a: assert property
		((!sample_valid && $stable(level_src) && $stable(level_below)) [*6] |=> $stable(level_state_r))
		else $error("level state changed without a sample");
endmodule : lsr_router_chk

bind lsr_router lsr_router_chk #(.N(N)) chk_u
(
	.clk_sys, .rst_n, .sample_valid, .level_src, .level_below, .setpt_src, .din_use, .dout_src, .remote_out,
	.stat_in_process, .dout_r, .level_state_r, .setpt_state_r, .cmd_tare_r, .cmd_zero_r, .cmd_print_r,
	.cmd_toggle_gn_r, .cmd_gross_r, .cmd_net_r, .cmd_weight_mode_r
);

// ==== sim/tb_lsr_router.sv ====
// self-checking bench for the level, setpoint and i/o router
`timescale 1ns/1ns
module tb_lsr_router;
	localparam int N = 4;
	localparam int W = 32;
	logic                clk_sys = 1'b0;
	logic                rst_n = 1'b0;
	logic                sample_valid = 1'b0;
	logic signed [W-1:0] net_weight = '0;
	logic signed [W-1:0] gross_weight = '0;
	logic signed [W-1:0] disp_weight = '0;
	logic [N*3-1:0]      level_src = '0;
	logic [N-1:0]        level_below = '0;
	logic [N*W-1:0]      level_value = '0;
	logic [N*W-1:0]      level_hyst = {N{lsr_pkg::HYST_DEFAULT}};
	logic [N*3-1:0]      setpt_src = '0;
	logic [N*W-1:0]      setpt_value = '0;
	logic [N*3-1:0]      din_use = '0;
	logic [N-1:0]        din_pin;
	logic [N-1:0]        sw_cmd = '0;
	logic [N*4-1:0]      dout_src = {N{lsr_pkg::DOUT_SRC_DEFAULT}};
	logic [N-1:0]        remote_out = '0;
	logic [3:0]          stat = '0;
	logic [N-1:0]        dout_r;
	logic [N-1:0]        level_state_r;
	logic [N-1:0]        setpt_state_r;
	wire [7:0]           cmd_v;
	logic [N-1:0]        din_level;
	logic [N-1:0]        ov = '0;
	logic [N-1:0]        sn = '0;
	logic [N-1:0]        spv = '0;
	logic [31:0]         lf = 32'ha113;
	int                  pulses[8];
	int                  failures = 0;
	int                  check_count = 0;

	assign cmd_v[0] = 1'b0;
	lsr_io_model io_u (.clk_sys, .sw_cmd, .din_pin);
	lsr_router dut_u
	(
		.clk_sys, .rst_n, .sample_valid, .net_weight, .gross_weight, .disp_weight, .level_src, .level_below,
		.level_value, .level_hyst, .setpt_src, .setpt_value, .din_use, .din_pin, .dout_src, .remote_out,
		.stat_in_process(stat[0]), .stat_net_mode(stat[1]), .stat_good_zero(stat[2]), .stat_stable(stat[3]),
		.dout_r, .level_state_r, .setpt_state_r, .din_level_r(din_level), .cmd_tare_r(cmd_v[1]),
		.cmd_toggle_gn_r(cmd_v[2]), .cmd_gross_r(cmd_v[3]), .cmd_net_r(cmd_v[4]), .cmd_zero_r(cmd_v[5]),
		.cmd_weight_mode_r(cmd_v[6]), .cmd_print_r(cmd_v[7])
	);

	initial
		forever #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
		for (int k = 1; k < 8; k++)
			if (cmd_v[k] === 1'b1)
				pulses[k]++;

	function automatic logic [31:0] nx(input logic [31:0] x);
		nx = {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
	endfunction : nx

	// codes 1 and 4 pick net, 2 and 5 gross, 3 and 6 displayed
	function automatic int sel(input int s);
		int v;
		v = s % 3 == 1 ? net_weight : s % 3 == 2 ? gross_weight : disp_weight;
		sel = (s > 3 && v < 0) ? -v : v;
	endfunction : sel

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic check_all();
		logic [3:0]  lv;
		logic [15:0] m;
		lv = sn & (ov ^ level_below);
		chk(level_state_r, lv);
		chk(setpt_state_r, spv);
		for (int i = 0; i < N; i++)
		begin
			m = {2'b00, stat[3:1], spv, lv, stat[0], remote_out[i], 1'b0};
			chk(dout_r[i], m[dout_src[i*4 +: 4]]);
		end
	endtask : check_all

	task automatic sample();
		int s;
		int v;
		int t;
		int h;
		lf = nx(lf);
		net_weight = int'(lf[10:0]) - 1000;
		gross_weight = int'(lf[21:11]) - 1000;
		disp_weight = int'(lf[31:21]) - 1000;
		sample_valid = 1'b1;
		for (int i = 0; i < N; i++)
		begin
			s = level_src[i*3 +: 3];
			v = sel(s);
			t = $signed(level_value[i*W +: W]);
			h = $signed(level_hyst[i*W +: W]);
			sn[i] = s != 0 && s != 7;
			if (!sn[i]) ov[i] = 1'b0;
			else if (v > t + (h > 0 ? h : 0)) ov[i] = 1'b1;
			else if (v < t + (h < 0 ? h : 0)) ov[i] = 1'b0;
			s = setpt_src[i*3 +: 3];
			v = sel(s);
			t = $signed(setpt_value[i*W +: W]);
			if (s == 0 || s == 7) spv[i] = 1'b0;
			else if (v != t) spv[i] = v > t;
		end
		@(negedge clk_sys);
		sample_valid = 1'b0;
		repeat (6) @(negedge clk_sys);
		check_all();
	endtask : sample

	task automatic test_done();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		chk(level_state_r | setpt_state_r | dout_r, 8'h0);
		remote_out = 4'ha;
		repeat (2) @(negedge clk_sys);
		check_all();
		for (int p = 0; p < 14; p++)
		begin
			lf = nx(lf);
			for (int i = 0; i < N; i++)
			begin
				level_src[i*3 +: 3] = p < 7 ? 3'((p + i) % 7) : lf[i*3 +: 3];
				setpt_src[i*3 +: 3] = p < 7 ? 3'((p + i + 3) % 7) : lf[i*3+12 +: 3];
				level_value[i*W +: W] = int'(lf[i*5 +: 8]) * 4 - 500;
				level_hyst[i*W +: W] = int'(lf[i*4+8 +: 6]) * 4 - 120;
				setpt_value[i*W +: W] = int'(lf[i*6 +: 7]) * 8 - 500;
				dout_src[i*4 +: 4] = p > 11 ? lf[i*4+8 +: 4] : 4'(p[0] ? 3 + i : 7 + i);
			end
			level_below = lf[27:24];
			remote_out = lf[31:28];
			stat = lf[23:20];
			repeat (12) sample();
		end
		for (int c = 0; c < 32; c++)
		begin
			lf = nx(lf);
			dout_src = {N{4'(c)}};
			remote_out = lf[3:0];
			stat = lf[7:4];
			repeat (2) @(negedge clk_sys);
			check_all();
		end
		// oversized hysteresis must be limited to 999999 units, band top at 99999900
		level_src = 12'h001;
		level_below = '0;
		level_value = '0;
		level_hyst = {N{32'sh7fff_ffff}};
		for (int k = 0; k < 2; k++)
		begin
			net_weight = k ? 32'sd99999901 : -32'sd1;
			sample_valid = 1'b1;
			@(negedge clk_sys);
			sample_valid = 1'b0;
			repeat (6) @(negedge clk_sys);
			chk(level_state_r, 8'(k));
		end
		for (int c = 0; c < 8; c++)
		begin
			din_use = {6'h0, 3'(c), 3'(c)};
			pulses = '{default: 0};
			repeat (2)
			begin
				sw_cmd = 4'h7;
				repeat (12) @(negedge clk_sys);
				chk(din_level, 8'h07);
				sw_cmd = 4'h0;
				repeat (12) @(negedge clk_sys);
				chk(din_level, 8'h00);
			end
			chk(8'(pulses[c]), 8'(c == 0 ? 0 : 2));
			chk(8'(pulses.sum()), 8'(c == 0 ? 0 : 2));
		end
		test_done();
	end

	// the whole sequence needs about 1650 cycles
	initial
	begin
		#100000;
		failures++;
		test_done();
	end
endmodule : tb_lsr_router
